// *** src/hcd_command_decode.v ***
// housekeeping command decode: serial load, strobe, register decode
`timescale 1ns/100ps
`default_nettype none
`include "hcd_cmd_map.vh"

// Operation
// - each channel word: route, buffer power, upper ref, lower ref, 10-bit code
// - route bit set closes buffer-to-pin switch
// - route bit clear opens buffer switch, closes unbuffered ladder switch
// - buffer power bit set powers the channel buffer
// - upper select set takes high reference from next higher channel
// - lower select clear uses ground reference, set uses next lower channel
// - exactly one of 35 analog sources reaches the modulator
// - 5-bit source select drives the 32-way selector
// - 2-bit divider select drives the 4-way supply selector
// - one selector bit connects the thermistor bias resistor
// - a 14-bit field sets modulator offset trim
// - modulator input buffer enabled or bypassed by command bits
// - twelve digital outputs follow their command bits
// - both command registers load from shift registers on strobe rise
// - each shift register shifts on rising edge of its own clock
// - power-on reset clears both command registers
module hcd_command_decode (
  input wire clk_i,
  input wire arst_n_i,
  input wire cmd_data_i,
  input wire mux_shift_clk_i,
  input wire dac_shift_clk_i,
  input wire cmd_load_strobe_i,
  output wire [`HCD_NUM_CH-1:0] dac_route_buf_o,
  output wire [`HCD_NUM_CH-1:0] dac_route_unbuf_o,
  output wire [`HCD_NUM_CH-1:0] dac_buf_power_o,
  output wire [`HCD_NUM_CH-1:0] dac_hi_from_upper_o,
  output wire [`HCD_NUM_CH-1:0] dac_hi_from_main_ref_o,
  output wire [`HCD_NUM_CH-1:0] dac_lo_from_lower_o,
  output wire [`HCD_NUM_CH-1:0] dac_lo_from_gnd_o,
  output wire [`HCD_NUM_CH*`HCD_CODE_W-1:0] ladder_code_o,
  output wire [`HCD_AIN_W-1:0] analog_source_select_o,
  output wire [`HCD_DIV_W-1:0] supply_divider_select_o,
  output wire [`HCD_NUM_SRC-1:0] source_onehot_o,
  output wire thermistor_bias_enable_o,
  output wire mod_in_buf_bypass_o,
  output wire mod_in_buf_amp_enable_o,
  output wire mod_buf_amp_enable_o,
  output wire forward_mode_o,
  output wire [`HCD_DOUT_W-1:0] digital_out_o,
  output wire [`HCD_TRIM_W-1:0] mod_offset_trim_o,
  output wire cmd_loaded_o
);

  // pin synchronisers: stage one feeds stage two only
  reg [`HCD_NUM_PIN-1:0] pin_meta_q;
  reg [`HCD_NUM_PIN-1:0] pin_sync_q;
  reg [`HCD_NUM_PIN-1:0] pin_prev_q;
  wire [`HCD_NUM_PIN-1:0] pin_raw;

  assign pin_raw[`HCD_PIN_DATA] = cmd_data_i;
  assign pin_raw[`HCD_PIN_MUXCLK] = mux_shift_clk_i;
  assign pin_raw[`HCD_PIN_DACCLK] = dac_shift_clk_i;
  assign pin_raw[`HCD_PIN_STROBE] = cmd_load_strobe_i;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_meta_q <= `HCD_PIN_RST;
      pin_sync_q <= `HCD_PIN_RST;
      pin_prev_q <= `HCD_PIN_RST;
    end else begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  wire data_bit;
  wire mux_shift_rise;
  wire dac_shift_rise;
  wire load_rise;

  assign data_bit = pin_sync_q[`HCD_PIN_DATA];
  assign mux_shift_rise = pin_sync_q[`HCD_PIN_MUXCLK] & ~pin_prev_q[`HCD_PIN_MUXCLK];
  assign dac_shift_rise = pin_sync_q[`HCD_PIN_DACCLK] & ~pin_prev_q[`HCD_PIN_DACCLK];
  assign load_rise = pin_sync_q[`HCD_PIN_STROBE] & ~pin_prev_q[`HCD_PIN_STROBE];

  // serial shift registers; new bits enter at bit 0 and move up
  reg [`HCD_MUX_W-1:0] mux_sr_q;
  reg [`HCD_DAC_W-1:0] dac_sr_q;

  // selector register: last bit shifted in lands in bit 0
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mux_sr_q <= `HCD_MUX_RST;
    end else if (mux_shift_rise) begin
      mux_sr_q <= {mux_sr_q[`HCD_MUX_W-2:0], data_bit};
    end
  end

  // converter register: first word shifted ends in the top channel slot
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dac_sr_q <= `HCD_DAC_RST;
    end else if (dac_shift_rise) begin
      dac_sr_q <= {dac_sr_q[`HCD_DAC_W-2:0], data_bit};
    end
  end

  // source decode of the pending selector word
  reg [`HCD_NUM_SRC-1:0] src_sel_d;
  wire [`HCD_AIN_W-1:0] ain_next;
  wire [`HCD_DIV_W-1:0] div_next;

  assign ain_next = mux_sr_q[`HCD_AIN_MSB:`HCD_AIN_LSB];
  assign div_next = mux_sr_q[`HCD_DIV_MSB:`HCD_DIV_LSB];

  // codes below the shared slot pick a primary input directly; the shared
  // slot hands the choice to the divider selector, so one source stays on
  always @* begin
    src_sel_d = {`HCD_NUM_SRC{1'b0}};
    if (ain_next == `HCD_AIN_SHARED) begin
      src_sel_d[`HCD_DIV_BASE + div_next] = 1'b1;
    end else begin
      src_sel_d[ain_next] = 1'b1;
    end
  end

  // command registers: parallel load on strobe rise, cleared at power-on
  reg [`HCD_MUX_W-1:0] mux_cmd_q;
  reg [`HCD_NUM_SRC-1:0] src_sel_q;
  reg [`HCD_TRIM_W-1:0] trim_q;
  reg loaded_q;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mux_cmd_q <= `HCD_MUX_RST;
      src_sel_q <= `HCD_SRC_RST;
      trim_q <= `HCD_TRIM_RST;
      loaded_q <= 1'b0;
    end else begin
      loaded_q <= load_rise;
      if (load_rise) begin
        mux_cmd_q <= mux_sr_q;
        src_sel_q <= src_sel_d;
        trim_q <= dac_sr_q[`HCD_TRIM_MSB:`HCD_TRIM_LSB];
      end
    end
  end

  // converter channels, each loading its slice on the same strobe
  genvar ch;
  generate
    for (ch = 0; ch < `HCD_NUM_CH; ch = ch + 1) begin : g_ch
      hcd_channel u_channel (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .load_i(load_rise),
        .word_i(dac_sr_q[`HCD_CH_BASE + ch*`HCD_WORD_W +: `HCD_WORD_W]),
        .route_buf_o(dac_route_buf_o[ch]),
        .route_unbuf_o(dac_route_unbuf_o[ch]),
        .buf_power_o(dac_buf_power_o[ch]),
        .hi_from_upper_o(dac_hi_from_upper_o[ch]),
        .hi_from_main_ref_o(dac_hi_from_main_ref_o[ch]),
        .lo_from_lower_o(dac_lo_from_lower_o[ch]),
        .lo_from_gnd_o(dac_lo_from_gnd_o[ch]),
        .ladder_code_o(ladder_code_o[ch*`HCD_CODE_W +: `HCD_CODE_W])
      );
    end
  endgenerate

  // selector fields straight from the command register flops
  assign analog_source_select_o = mux_cmd_q[`HCD_AIN_MSB:`HCD_AIN_LSB];
  assign supply_divider_select_o = mux_cmd_q[`HCD_DIV_MSB:`HCD_DIV_LSB];
  assign source_onehot_o = src_sel_q;
  assign thermistor_bias_enable_o = mux_cmd_q[`HCD_THERM_BIT];
  assign mod_in_buf_bypass_o = mux_cmd_q[`HCD_BYPASS_BIT];
  assign mod_in_buf_amp_enable_o = mux_cmd_q[`HCD_INAMP_BIT];
  assign mod_buf_amp_enable_o = mux_cmd_q[`HCD_BUFON_BIT];
  assign forward_mode_o = mux_cmd_q[`HCD_FWD_BIT];
  assign digital_out_o = mux_cmd_q[`HCD_DOUT_MSB:`HCD_DOUT_LSB];
  assign mod_offset_trim_o = trim_q;
  assign cmd_loaded_o = loaded_q;

endmodule

`default_nettype wire

// *** src/hcd_cmd_map.vh ***
// constant map of the housekeeping command decode block
`ifndef HCD_CMD_MAP_VH
`define HCD_CMD_MAP_VH

// converter channels and control word layout
`define HCD_NUM_CH 12
`define HCD_WORD_W 14
`define HCD_CODE_W 10
`define HCD_CODE_MSB 9
`define HCD_ROUTE_BIT 13
`define HCD_BUFPWR_BIT 12
`define HCD_HISEL_BIT 11
`define HCD_LOSEL_BIT 10
`define HCD_WORD_RST 14'h0000

// selector command register, bit 0 is the last bit shifted in
`define HCD_MUX_W 24
`define HCD_MUX_RST 24'h000000
`define HCD_AIN_LSB 0
`define HCD_AIN_MSB 4
`define HCD_BYPASS_BIT 5
`define HCD_INAMP_BIT 6
`define HCD_THERM_BIT 7
`define HCD_BUFON_BIT 8
`define HCD_DIV_LSB 9
`define HCD_DIV_MSB 10
`define HCD_FWD_BIT 11
`define HCD_DOUT_LSB 12
`define HCD_DOUT_MSB 23
`define HCD_DOUT_W 12

// converter command register: channel 11 shifted first, trim last
`define HCD_DAC_W 182
`define HCD_DAC_RST 182'h0
`define HCD_TRIM_LSB 0
`define HCD_TRIM_MSB 13
`define HCD_TRIM_W 14
`define HCD_TRIM_RST 14'h0000
`define HCD_CH_BASE 14

// analog source selector
`define HCD_NUM_SRC 35
`define HCD_AIN_W 5
`define HCD_DIV_W 2
`define HCD_AIN_SHARED 5'h1F
`define HCD_DIV_BASE 6'h1F
`define HCD_SRC_RST 35'h000000001

// pin synchroniser
`define HCD_NUM_PIN 4
`define HCD_PIN_DATA 0
`define HCD_PIN_MUXCLK 1
`define HCD_PIN_DACCLK 2
`define HCD_PIN_STROBE 3
`define HCD_PIN_RST 4'h0

`endif

// *** src/hcd_channel.v ***
// one converter channel: control word hold and switch decode
`timescale 1ns/100ps
`default_nettype none
`include "hcd_cmd_map.vh"

module hcd_channel (
  input wire clk_i,
  input wire arst_n_i,
  input wire load_i,
  input wire [`HCD_WORD_W-1:0] word_i,
  output wire route_buf_o,
  output wire route_unbuf_o,
  output wire buf_power_o,
  output wire hi_from_upper_o,
  output wire hi_from_main_ref_o,
  output wire lo_from_lower_o,
  output wire lo_from_gnd_o,
  output wire [`HCD_CODE_W-1:0] ladder_code_o
);

  reg route_buf_q;
  reg route_unbuf_q;
  reg buf_power_q;
  reg hi_upper_q;
  reg hi_main_q;
  reg lo_lower_q;
  reg lo_gnd_q;
  reg [`HCD_CODE_W-1:0] code_q;

  // cleared word: unbuffered output, buffer off, main ref and ground ref
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      route_buf_q <= 1'b0;
      route_unbuf_q <= 1'b1;
      buf_power_q <= 1'b0;
      hi_upper_q <= 1'b0;
      hi_main_q <= 1'b1;
      lo_lower_q <= 1'b0;
      lo_gnd_q <= 1'b1;
      code_q <= {`HCD_CODE_W{1'b0}};
    end else if (load_i) begin
      route_buf_q <= word_i[`HCD_ROUTE_BIT];
      route_unbuf_q <= ~word_i[`HCD_ROUTE_BIT];
      buf_power_q <= word_i[`HCD_BUFPWR_BIT];
      hi_upper_q <= word_i[`HCD_HISEL_BIT];
      hi_main_q <= ~word_i[`HCD_HISEL_BIT];
      lo_lower_q <= word_i[`HCD_LOSEL_BIT];
      lo_gnd_q <= ~word_i[`HCD_LOSEL_BIT];
      code_q <= word_i[`HCD_CODE_MSB:0];
    end
  end

  assign route_buf_o = route_buf_q;
  assign route_unbuf_o = route_unbuf_q;
  assign buf_power_o = buf_power_q;
  assign hi_from_upper_o = hi_upper_q;
  assign hi_from_main_ref_o = hi_main_q;
  assign lo_from_lower_o = lo_lower_q;
  assign lo_from_gnd_o = lo_gnd_q;
  assign ladder_code_o = code_q;

endmodule

`default_nettype wire

// *** tb/hcd_command_decode_monitor.sv ***
// checker for the housekeeping command decode ports
`timescale 1ns/100ps
`default_nettype none
module hcd_command_decode_monitor (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic cmd_load_strobe_i,
  input wire logic [11:0] dac_route_buf_o,
  input wire logic [11:0] dac_route_unbuf_o,
  input wire logic [11:0] dac_hi_from_upper_o,
  input wire logic [11:0] dac_hi_from_main_ref_o,
  input wire logic [11:0] dac_lo_from_lower_o,
  input wire logic [11:0] dac_lo_from_gnd_o,
  input wire logic [4:0] analog_source_select_o,
  input wire logic [1:0] supply_divider_select_o,
  input wire logic [34:0] source_onehot_o,
  input wire logic cmd_loaded_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  a_route_excl: assert property (dac_route_unbuf_o == ~dac_route_buf_o)
    else $error("route switches overlap");
  a_hi_ref_excl: assert property (dac_hi_from_main_ref_o == ~dac_hi_from_upper_o)
    else $error("high reference choice wrong");
  a_lo_ref_excl: assert property (dac_lo_from_gnd_o == ~dac_lo_from_lower_o)
    else $error("low reference choice wrong");
  a_src_single: assert property ($onehot(source_onehot_o))
    else $error("source select not one-hot");
  a_src_primary: assert property (analog_source_select_o != 5'h1F |->
    source_onehot_o == (35'h1 << analog_source_select_o)) else $error("primary source wrong");
  a_src_divider: assert property (analog_source_select_o == 5'h1F |->
    source_onehot_o == (35'h1 << (31 + supply_divider_select_o))) else $error("divider source wrong");
  a_strobe_loads: assert property ($rose(cmd_load_strobe_i) |-> ##[2:5] cmd_loaded_o)
    else $error("strobe did not load");
  a_loaded_pulse: assert property (cmd_loaded_o |=> !cmd_loaded_o)
    else $error("load pulse too long");
  a_out_hold: assert property (($changed(dac_route_buf_o) || $changed(source_onehot_o)) |->
    ##[0:1] cmd_loaded_o) else $error("outputs changed without load");
  cover property (cmd_loaded_o);
  cover property (analog_source_select_o == 5'h1F);
  cover property (|dac_hi_from_upper_o);
endmodule
bind hcd_command_decode hcd_command_decode_monitor u_mon (.*);
`default_nettype wire

// *** tb/hcd_ctl_model.sv ***
// controller model: serial command words and load strobe
`timescale 1ns/100ps
`default_nettype none
module hcd_ctl_model (
  output logic data_o,
  output logic mux_clk_o,
  output logic dac_clk_o,
  output logic strobe_o
);
  initial begin
    data_o = 1'b0;
    mux_clk_o = 1'b0;
    dac_clk_o = 1'b0;
    strobe_o = 1'b0;
  end
  // msb first, one bit per 160 ns link period, clocks idle low between frames
  task automatic shift(input logic sel, input logic [181:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      data_o = v[i];
      #80;
      if (sel) dac_clk_o = 1'b1; else mux_clk_o = 1'b1;
      #80;
      mux_clk_o = 1'b0;
      dac_clk_o = 1'b0;
    end
    data_o = ~data_o;
  endtask
  task automatic strobe(input logic lvl);
    strobe_o = lvl;
  endtask
endmodule
`default_nettype wire

// *** tb/hcd_command_decode_test.sv ***
// self-checking bench for the housekeeping command decode
`timescale 1ns/100ps
`default_nettype none
`define chk(a, b) begin compares++; if ((a) !== (b)) begin fails++; $display("Error %0t: got %h want %h", $time, a, b); end end
module hcd_command_decode_test;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  wire cmd_data_i, mux_shift_clk_i, dac_shift_clk_i, cmd_load_strobe_i;
  wire [11:0] dac_route_buf_o, dac_route_unbuf_o, dac_buf_power_o, dac_hi_from_upper_o;
  wire [11:0] dac_hi_from_main_ref_o, dac_lo_from_lower_o, dac_lo_from_gnd_o, digital_out_o;
  wire [119:0] ladder_code_o;
  wire [4:0] analog_source_select_o;
  wire [1:0] supply_divider_select_o;
  wire [34:0] source_onehot_o;
  wire [13:0] mod_offset_trim_o;
  wire thermistor_bias_enable_o, mod_in_buf_bypass_o, mod_in_buf_amp_enable_o;
  wire mod_buf_amp_enable_o, forward_mode_o, cmd_loaded_o;
  int fails = 0;
  int compares = 0;
  hcd_command_decode u_dut (.*);
  hcd_ctl_model u_ctl (.data_o(cmd_data_i), .mux_clk_o(mux_shift_clk_i), .dac_clk_o(dac_shift_clk_i),
    .strobe_o(cmd_load_strobe_i));
  always #10 clk_i = ~clk_i;
  task automatic complete_run;
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic load_cmd;
    int n;
    n = 0;
    u_ctl.strobe(1'b1);
    while (cmd_loaded_o !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    u_ctl.strobe(1'b0);
    if (n == 20) begin
      fails++;
      complete_run();
    end
    @(negedge clk_i);
  endtask
  task automatic test_reset;
    `chk(dac_route_unbuf_o, 12'hFFF)
    `chk(dac_hi_from_main_ref_o, 12'hFFF)
    `chk(dac_lo_from_gnd_o, 12'hFFF)
    `chk({dac_route_buf_o, dac_buf_power_o, digital_out_o, mod_offset_trim_o}, 50'h0)
    `chk({dac_hi_from_upper_o, dac_lo_from_lower_o, ladder_code_o, analog_source_select_o,
      supply_divider_select_o}, 151'h0)
    `chk({thermistor_bias_enable_o, mod_in_buf_bypass_o, mod_in_buf_amp_enable_o, mod_buf_amp_enable_o,
      forward_mode_o, cmd_loaded_o}, 6'h0)
    `chk(source_onehot_o, 35'h1)
  endtask
  task automatic test_mux;
    logic [23:0] w;
    logic [4:0] ain;
    logic [1:0] div;
    for (int j = 0; j < 6; j++) begin
      ain = (j < 4) ? 5'h1F : ((j == 4) ? 5'h1E : 5'h00);
      div = j[1:0];
      // forward select alternates; input amp enable follows ~j[1], buffer amp enable ~j[0]
      w = {12'hA5C ^ 12'(j), j[0], div, ~j[0], j[1], ~j[1], j[0], ain};
      u_ctl.shift(1'b0, 182'(w), 24);
      load_cmd();
      `chk(analog_source_select_o, ain)
      `chk(supply_divider_select_o, div)
      `chk(source_onehot_o, (ain == 5'h1F) ? 35'h1 << (31 + div) : 35'h1 << ain)
      `chk(digital_out_o, 12'hA5C ^ 12'(j))
      `chk({forward_mode_o, supply_divider_select_o, mod_buf_amp_enable_o, thermistor_bias_enable_o,
        mod_in_buf_amp_enable_o, mod_in_buf_bypass_o}, w[11:5])
    end
  endtask
  task automatic test_dac;
    logic [181:0] v;
    logic [13:0] w;
    v = 182'h0;
    v[13:0] = 14'h2B7D;
    // every buffer powered, so neighbour references are always legal
    for (int k = 0; k < 12; k++) v[14 + 14 * k +: 14] = {k[0], 1'b1, k[1], k[2], 10'(10'h3A5 ^ (k * 37))};
    u_ctl.shift(1'b1, v, 182);
    `chk(dac_route_buf_o, 12'h000)
    load_cmd();
    `chk(mod_offset_trim_o, 14'h2B7D)
    `chk(digital_out_o, 12'hA5C ^ 12'h005)
    for (int k = 0; k < 12; k++) begin
      w = v[14 + 14 * k +: 14];
      `chk({dac_route_buf_o[k], dac_buf_power_o[k], dac_hi_from_upper_o[k], dac_lo_from_lower_o[k],
        ladder_code_o[10 * k +: 10]}, w)
      `chk({dac_route_unbuf_o[k], dac_hi_from_main_ref_o[k], dac_lo_from_gnd_o[k]}, ~{w[13], w[11], w[10]})
    end
  endtask
  initial begin
    repeat (3) @(negedge clk_i);
    arst_n_i = 1'b1;
    test_reset();
    test_mux();
    test_dac();
    arst_n_i = 1'b0;
    @(negedge clk_i);
    arst_n_i = 1'b1;
    test_reset();
    complete_run();
  end
endmodule
`default_nettype wire
